// [logic/prot_pkg.sv]
// Purpose: shared types and constants for the protection trip voting logic
// Assumes: ref_clk at 250 MHz, four divisions
// Notes:   bus offsets are byte addresses of aligned 32-bit words
package prot_pkg;

  localparam int unsigned NUM_DIV = 4;

  // per-division trip conditions from the sensor channels, one bit each
  typedef struct packed {
    logic drywellPressHigh;
    logic stopValveClosure;
    logic controlValveFastClosure;
    logic powerRangeFluxTrip;
    logic sourceRangeFluxTrip;
    logic vesselPressHigh;
    logic levelLow3;
    logic levelHigh8;
    logic isolationValveClosed;
    logic headerPressLow;
    logic poolTempHigh;
    logic vacuumLow;
    logic feedwaterLoss;
  } cond_t;

  localparam int unsigned COND_W = $bits(cond_t);

  // operating mode selector codes
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_REFUEL   = 2'h1;
  localparam logic [1:0] MODE_STARTUP  = 2'h2;
  localparam logic [1:0] MODE_RUN      = 2'h3;

  // software control register contents
  typedef struct packed {
    logic [3:0] actForce;
    logic [3:0] divForce;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{actForce: 4'h0, divForce: 4'h0};

  // register byte offsets
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h4;
  localparam logic [3:0] OFS_DIV_ALARM = 4'h8;
  localparam logic [3:0] OFS_COND_ALM  = 4'hc;

  // status register field positions
  localparam int unsigned ST_SHUTDOWN  = 0;
  localparam int unsigned ST_AUTO      = 1;
  localparam int unsigned ST_MANUAL    = 2;
  localparam int unsigned ST_DELAY     = 3;
  localparam int unsigned ST_DIV_TRIP  = 4;
  localparam int unsigned ST_LOAD_OPEN = 8;
  localparam int unsigned ST_SENS_BYP  = 12;
  localparam int unsigned ST_TLU_BYP   = 16;
  localparam int unsigned ST_PROC_ALM  = 20;
  localparam int unsigned ST_FLUX_ALM  = 21;
  localparam int unsigned ST_MODE_SD   = 22;

  // reset permissive delay after a shutdown latches
  localparam int unsigned CLK_MHZ            = 250;
  localparam int unsigned RESET_DELAY_US     = 10000;
  localparam int unsigned RESET_DELAY_CYCLES = RESET_DELAY_US * CLK_MHZ;

  // per-division alarm word: auto, manual test, sensors bypassed, unit out of service
  typedef struct packed {
    logic [3:0] tluOutOfService;
    logic [3:0] sensorsBypassed;
    logic [3:0] manualTrip;
    logic [3:0] autoTrip;
  } div_alarm_t;

  // state of the voting core
  typedef struct packed {
    logic        autoLatch;
    logic        manLatch;
    logic [3:0]  loadOpen;
    ctrl_t       ctrl;
    logic        ack;
    logic [31:0] readData;
    div_alarm_t  divAlarm;
    cond_t       condAlarm;
    logic        processAlarm;
    logic        fluxModeAlarm;
  } core_st_t;

  // state of the reset delay timer
  typedef struct packed {
    logic [31:0] cnt;
    logic        done;
  } timer_st_t;

endpackage

// [logic/sync_stage.sv]
// Purpose: two flip-flop synchroniser for a bundle of pin levels
// Assumes: every bit is an independent level, no multi-bit coherence needed
// Notes:   first stage feeds the second stage only
module sync_stage #(
  parameter int unsigned W = 1
)(
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_st_t;

  sync_st_t st;
  sync_st_t next_st;

  // shift pins through two stages
  always_comb begin
    next_st.meta   = din;
    next_st.stable = st.meta;
  end

  // zero at reset reads as power lost, so loads start open
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule

// [logic/delay_timer.sv]
// Purpose: counts a fixed delay while run is high
// Assumes: LIMIT is at least one cycle
// Notes:   done stays high until run drops, which clears the count
module delay_timer #(
  parameter int unsigned LIMIT = 1
)(
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic run,
  output logic      done
);

  prot_pkg::timer_st_t st;
  prot_pkg::timer_st_t next_st;

  // count up to the limit, then hold
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.cnt  = 32'h0;
      next_st.done = 1'b0;
    end else if (!st.done) begin
      next_st.cnt  = st.cnt + 32'h1;
      next_st.done = (st.cnt + 32'h1) >= LIMIT;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

endmodule

// [logic/protection_trip_voting_logic.sv]
// Purpose: four-division trip voting, shutdown latch, bypasses and alarms
// Assumes: all pin inputs asynchronous; Avalon-MM slave on ref_clk
// Notes:   loadOpen high means the load driver is open, the tripped state
module protection_trip_voting_logic #(
  parameter int unsigned RESET_DELAY_CYCLES = prot_pkg::RESET_DELAY_CYCLES
)(
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire prot_pkg::cond_t [3:0]  divCond,
  input  wire logic [3:0]             capInsufficient,
  input  wire logic [3:0]             sensorBypassReq,
  input  wire logic [3:0]             tluBypassReq,
  input  wire logic [3:0]             divPowerGood,
  input  wire logic                   manualA,
  input  wire logic                   manualB,
  input  wire logic [1:0]             modeSel,
  input  wire logic                   fluxNonCoincident,
  input  wire logic                   headerBypassSw,
  input  wire logic                   resetAuto,
  input  wire logic                   resetManual,
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  output logic                        shutdownCmd,
  output logic [3:0]                  loadOpen,
  output logic                        processAlarm,
  output logic                        fluxModeAlarm,
  output prot_pkg::div_alarm_t        divAlarm
);

  localparam int unsigned SYNC_W = 4 * prot_pkg::COND_W + 16 + 2 + 2 + 4;

  // population count of a four-bit vector
  function automatic logic [2:0] countOnes4(input logic [3:0] v);
    return {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
  endfunction

  // keep only the lowest set bit of a request vector
  function automatic logic [3:0] firstOne4(input logic [3:0] v);
    return v & (~v + 4'h1);
  endfunction

  prot_pkg::core_st_t st;
  prot_pkg::core_st_t next_st;

  logic [SYNC_W-1:0]     rawIn;
  logic [SYNC_W-1:0]     syncIn;
  prot_pkg::cond_t [3:0] sCond;
  prot_pkg::cond_t [3:0] masked;
  logic [3:0]            sCap;
  logic [3:0]            sSensByp;
  logic [3:0]            sTluByp;
  logic [3:0]            sPower;
  logic                  sManA;
  logic                  sManB;
  logic [1:0]            sMode;
  logic                  sFluxNc;
  logic                  sHdrByp;
  logic                  sRstAuto;
  logic                  sRstMan;

  logic [3:0]            sensByp;
  logic [3:0]            tluByp;
  logic [3:0]            divTrip;
  logic [3:0]            autoTrip;
  logic                  autoVote;
  logic [3:0]            tluOut;
  logic                  outVote;
  logic                  manualCmd;
  logic                  modeShut;
  logic                  runMode;
  logic                  latched;
  logic                  delayDone;
  logic                  autoClear;
  logic                  manClear;
  logic                  busReq;
  logic [31:0]           statusWord;
  prot_pkg::cond_t       anyCond;

  // every sensor and switch pin passes two flops before any logic reads it
  assign rawIn = {divCond, capInsufficient, sensorBypassReq, tluBypassReq, divPowerGood,
                  manualA, manualB, modeSel, fluxNonCoincident, headerBypassSw,
                  resetAuto, resetManual};

  sync_stage #(
    .W (SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (rawIn),
    .dout    (syncIn)
  );

  assign {sCond, sCap, sSensByp, sTluByp, sPower, sManA, sManB, sMode, sFluxNc,
          sHdrByp, sRstAuto, sRstMan} = syncIn;

  // mode decode
  assign modeShut = sMode == prot_pkg::MODE_SHUTDOWN;
  assign runMode  = sMode == prot_pkg::MODE_RUN;
  assign latched  = st.autoLatch | st.manLatch;

  // a request above the lowest-numbered one is ignored rather than dropping two divisions out
  assign sensByp = firstOne4(sSensByp);
  assign tluByp  = firstOne4(sTluByp);

  // per-division condition masking and divisional trip, four copies
  always_comb begin
    masked  = sCond;
    divTrip = 4'h0;
    for (int d = 0; d < prot_pkg::NUM_DIV; d++) begin
      // stop and control valve closures matter only without enough bypass capacity
      masked[d].stopValveClosure = sCond[d].stopValveClosure & sCap[d];
      masked[d].controlValveFastClosure =
        sCond[d].controlValveFastClosure & sCap[d];
      masked[d].isolationValveClosed = sCond[d].isolationValveClosed & runMode;
      masked[d].sourceRangeFluxTrip = sCond[d].sourceRangeFluxTrip & ~runMode;
      masked[d].headerPressLow =
        sCond[d].headerPressLow & ~(sHdrByp & latched);
      // level 3 and level 8 pass unmasked
      divTrip[d] = (|masked[d]) | modeShut | st.ctrl.divForce[d];
    end
  end

  // automatic vote over unbypassed divisions; bypass leaves two of three
  assign autoTrip = divTrip & ~sensByp;
  assign autoVote = countOnes4(autoTrip) >= 3'h2;

  // division outputs; a dead division fails toward trip
  assign tluOut  = {4{autoVote}} | st.ctrl.actForce | ~sPower;
  assign outVote = countOnes4(tluOut & ~tluByp) >= 3'h2;

  // manual path needs both channels and bypasses the vote entirely
  assign manualCmd = sManA & sManB;

  // clear only when delay expired, reset asked and inputs quiet, same cycle
  assign autoClear = sRstAuto & delayDone & ~outVote & ~(|autoTrip);
  assign manClear  = sRstMan & delayDone & ~sManA & ~sManB;

  // reset permissive timer, runs from the moment the latch sets
  delay_timer #(
    .LIMIT (RESET_DELAY_CYCLES)
  ) u_delay (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .run     (latched),
    .done    (delayDone)
  );

  // raw limit crossings per condition, any division
  always_comb begin
    anyCond = '0;
    for (int d = 0; d < prot_pkg::NUM_DIV; d++) begin
      anyCond = anyCond | sCond[d];
    end
  end

  // status word image
  always_comb begin
    statusWord = 32'h0;
    statusWord[prot_pkg::ST_SHUTDOWN] = latched;
    statusWord[prot_pkg::ST_AUTO] = st.autoLatch;
    statusWord[prot_pkg::ST_MANUAL] = st.manLatch;
    statusWord[prot_pkg::ST_DELAY] = delayDone;
    statusWord[prot_pkg::ST_DIV_TRIP +: 4] = divTrip;
    statusWord[prot_pkg::ST_LOAD_OPEN +: 4] = st.loadOpen;
    statusWord[prot_pkg::ST_SENS_BYP +: 4] = sensByp;
    statusWord[prot_pkg::ST_TLU_BYP +: 4] = tluByp;
    statusWord[prot_pkg::ST_PROC_ALM] = st.processAlarm;
    statusWord[prot_pkg::ST_FLUX_ALM] = st.fluxModeAlarm;
    statusWord[prot_pkg::ST_MODE_SD] = modeShut;
  end

  assign busReq = read | write;

  // next state of latches, outputs, alarms and bus slave
  always_comb begin
    next_st = st;

    // sticky once set; a new trip in the clear cycle keeps it set
    next_st.autoLatch = outVote | (st.autoLatch & ~autoClear);
    next_st.manLatch  = manualCmd | (st.manLatch & ~manClear);

    // all loads open on shutdown, otherwise only the division's own
    next_st.loadOpen = {4{outVote | manualCmd | latched}} | tluOut;

    // alarms toward the control room
    next_st.condAlarm     = anyCond;
    next_st.processAlarm  = |anyCond;
    next_st.fluxModeAlarm = sFluxNc & runMode;
    next_st.divAlarm.autoTrip        = divTrip & ~st.ctrl.divForce;
    next_st.divAlarm.manualTrip      = st.ctrl.divForce | st.ctrl.actForce;
    next_st.divAlarm.sensorsBypassed = sensByp;
    next_st.divAlarm.tluOutOfService = tluByp;

    // one wait cycle: ack rises, then the master samples waitrequest low
    next_st.ack = busReq & ~st.ack;
    if (read & ~st.ack) begin
      unique case (address)
        prot_pkg::OFS_CTRL:      next_st.readData = {24'h0, st.ctrl};
        prot_pkg::OFS_STATUS:    next_st.readData = statusWord;
        prot_pkg::OFS_DIV_ALARM: next_st.readData = {16'h0, st.divAlarm};
        prot_pkg::OFS_COND_ALM:  next_st.readData = {19'h0, st.condAlarm};
        default:                 next_st.readData = 32'h0;
      endcase
    end

    // write lands on the edge where waitrequest is low
    if (write & st.ack & (address == prot_pkg::OFS_CTRL) & byteenable[0]) begin
      next_st.ctrl = prot_pkg::ctrl_t'(writedata[7:0]);
    end
  end

  // state register; loads start open and stay open until the startup shutdown is reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st               <= '0;
      st.ctrl          <= prot_pkg::CTRL_RESET;
      st.loadOpen      <= 4'hf;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign waitrequest   = busReq & ~st.ack;
  assign readdata      = st.readData;
  assign shutdownCmd   = st.autoLatch | st.manLatch;
  assign loadOpen      = st.loadOpen;
  assign processAlarm  = st.processAlarm;
  assign fluxModeAlarm = st.fluxModeAlarm;
  assign divAlarm      = st.divAlarm;

endmodule

// [testbench/protection_trip_voting_assertions.sv]
// Purpose: concurrent checks on the trip voting ports
// Assumes: a pin change reaches the outputs three edges later
// Notes:   bound to every instance of the voting top
module protection_trip_voting_checker (
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire prot_pkg::cond_t [3:0] divCond,
  input wire logic [3:0]            tluBypassReq,
  input wire logic [3:0]            divPowerGood,
  input wire logic                  manualA,
  input wire logic                  manualB,
  input wire logic [1:0]            modeSel,
  input wire logic                  fluxNonCoincident,
  input wire logic                  resetAuto,
  input wire logic                  resetManual,
  input wire logic                  read,
  input wire logic                  write,
  input wire logic                  waitrequest,
  input wire logic                  shutdownCmd,
  input wire logic [3:0]            loadOpen,
  input wire logic                  processAlarm,
  input wire logic                  fluxModeAlarm
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] rstHist;
  // recent reset requests; the sync delay makes a clear lag the pin
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) rstHist <= 5'h00;
    else rstHist <= {rstHist[3:0], resetAuto | resetManual};
  end
  sequence quiet_reset;
    (!resetAuto && !resetManual)[*4];
  endsequence
  sequence both_pressed;
    (manualA && manualB)[*4];
  endsequence
  chk_latch_holds: assert property (quiet_reset ##0 shutdownCmd |=> shutdownCmd)
    else $error("shutdown dropped without a reset request");
  chk_clear_needs_reset: assert property ($fell(shutdownCmd) |-> rstHist != 5'h00)
    else $error("shutdown cleared with no recent reset request");
  chk_manual_sets: assert property (both_pressed |=> shutdownCmd)
    else $error("both manual channels pressed but no shutdown");
  chk_power_opens: assert property ((!divPowerGood[0])[*4] |=> loadOpen[0])
    else $error("unpowered division load driver still closed");
  chk_output_vote: assert property ((tluBypassReq == 4'h0)[*4] ##0
    ($countones(loadOpen) >= 2 && $countones($past(loadOpen)) < 2) |-> ##[0:3] shutdownCmd)
    else $error("two division outputs open without shutdown");
  chk_mode_trip: assert property ((modeSel == prot_pkg::MODE_SHUTDOWN)[*4] |=> shutdownCmd)
    else $error("shutdown mode did not trip");
  chk_flux_alarm: assert property ((fluxNonCoincident && modeSel == prot_pkg::MODE_RUN)[*4]
    |=> fluxModeAlarm)
    else $error("flux selector alarm missing in run mode");
  chk_flux_quiet: assert property ((!fluxNonCoincident)[*4] |=> !fluxModeAlarm)
    else $error("flux selector alarm without cause");
  chk_process_alarm: assert property ((divCond != '0)[*4] |=> processAlarm)
    else $error("trip condition present but no process alarm");
  chk_bus_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("bus answer not after exactly one wait cycle");
  chk_bus_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest high while idle");
endmodule

bind protection_trip_voting_logic protection_trip_voting_checker chk (.ref_clk, .reset_n,
  .divCond, .tluBypassReq, .divPowerGood, .manualA, .manualB, .modeSel, .fluxNonCoincident,
  .resetAuto, .resetManual, .read, .write, .waitrequest, .shutdownCmd, .loadOpen,
  .processAlarm, .fluxModeAlarm);

// [testbench/sensor_field_model.sv]
// Purpose: sensor field model, raises one trip condition in chosen divisions
// Assumes: commands from the bench change just after a rising edge
// Notes:   registered, so pins move one edge after the command
module sensor_field_model (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [3:0]       tripDiv,
  input  wire logic [3:0]       condBit,
  output prot_pkg::cond_t [3:0] divCond
);
  timeunit 1ns;
  timeprecision 1ps;
  // one mask bit per division, each its own sensor set
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCond <= '0;
    end else begin
      for (int d = 0; d < 4; d++) begin
        divCond[d] <= tripDiv[d] ? prot_pkg::cond_t'(13'h0001 << condBit) : '0;
      end
    end
  end
endmodule

// [testbench/protection_trip_voting_logic_test.sv]
// Purpose: self-checking bench for the trip voting block
// Assumes: reset permissive delay shortened to sixteen cycles
// Notes:   sensor pins come from the field model one edge late
module protection_trip_voting_logic_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DLY = 16;
  localparam logic [1:0] R = prot_pkg::MODE_RUN;
  localparam logic [1:0] S = prot_pkg::MODE_STARTUP;
  logic ref_clk, reset_n, manualA, manualB, fluxNonCoincident, resetAuto, resetManual;
  logic read, write, waitrequest, shutdownCmd, processAlarm, fluxModeAlarm, headerBypassSw;
  logic [3:0]            tripDiv, condBit, capInsufficient, sensorBypassReq, divPowerGood;
  logic [3:0]            address, loadOpen, tluBypassReq;
  logic [1:0]            modeSel;
  logic [31:0]           writedata, readdata, rdv;
  prot_pkg::cond_t [3:0] divCond;
  prot_pkg::div_alarm_t  divAlarm;
  int                    miscompares, checked, cycles;
  // condition table: bit, mode, capacity, expected shutdown
  logic [3:0] cbit [9] = '{4'h4, 4'h4, 4'hb, 4'hb, 4'ha, 4'h6, 4'h5, 4'h8, 4'h8};
  logic [1:0] cmode [9] = '{R, prot_pkg::MODE_REFUEL, R, R, R, R, R, R, S};
  logic [8:0] ccap = 9'h018;
  logic [8:0] cexp = 9'h179;

  sensor_field_model field (.ref_clk(ref_clk), .reset_n(reset_n), .tripDiv(tripDiv),
    .condBit(condBit), .divCond(divCond));
  // every switch input is driven so the bypass rules can be exercised
  protection_trip_voting_logic #(.RESET_DELAY_CYCLES(DLY)) dut (.ref_clk(ref_clk),
    .reset_n(reset_n), .divCond(divCond), .capInsufficient(capInsufficient),
    .sensorBypassReq(sensorBypassReq), .tluBypassReq(tluBypassReq),
    .divPowerGood(divPowerGood), .manualA(manualA), .manualB(manualB), .modeSel(modeSel),
    .fluxNonCoincident(fluxNonCoincident), .headerBypassSw(headerBypassSw),
    .resetAuto(resetAuto), .resetManual(resetManual), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .shutdownCmd(shutdownCmd), .loadOpen(loadOpen),
    .processAlarm(processAlarm), .fluxModeAlarm(fluxModeAlarm), .divAlarm(divAlarm));

  task automatic end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // waits n edges; outputs read here still hold their pre-edge values
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one avalon transfer; held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    @(posedge ref_clk);
    read <= !wr;
    write <= wr;
    address <= adr;
    writedata <= wd;
    // the edge that sees waitrequest low completes the transfer
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rdv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // drop every pin cause, wait out the delay, then reset both latches
  task automatic clear_all;
    tripDiv <= 4'h0;
    manualA <= 1'b0;
    manualB <= 1'b0;
    modeSel <= R;
    divPowerGood <= 4'hf;
    cyc(DLY + 6);
    resetAuto <= 1'b1;
    resetManual <= 1'b1;
    cyc(6);
    resetAuto <= 1'b0;
    resetManual <= 1'b0;
    cyc(6);
    check(shutdownCmd, 1'b0);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard, far above the fewer than one thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  initial begin
    reset_n = 1'b0; tripDiv = 4'h0; condBit = 4'hc; capInsufficient = 4'h0;
    sensorBypassReq = 4'h0; divPowerGood = 4'hf; manualA = 1'b0; manualB = 1'b0;
    modeSel = R; fluxNonCoincident = 1'b0; resetAuto = 1'b0; resetManual = 1'b0;
    address = 4'h0; read = 1'b0; write = 1'b0; writedata = 32'h0;
    tluBypassReq = 4'h0; headerBypassSw = 1'b0;
    cyc(6);
    check(loadOpen, 4'hf);
    reset_n <= 1'b1;
    cyc(6);
    // synchroniser zeros read as every division unpowered, so it starts tripped
    check(shutdownCmd, 1'b1);
    check(loadOpen, 4'hf);
    clear_all();
    check(loadOpen, 4'h0);
    bus(1'b0, prot_pkg::OFS_CTRL, 32'h0);
    check(rdv, 32'h0);
    bus(1'b1, prot_pkg::OFS_STATUS, 32'hffffffff);
    bus(1'b0, prot_pkg::OFS_STATUS, 32'h0);
    check(rdv, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    check(rdv, 32'h0);
    tripDiv <= 4'h1;
    cyc(6);
    check(shutdownCmd, 1'b0);
    check(divAlarm, 16'h0001);
    check(processAlarm, 1'b1);
    bus(1'b0, prot_pkg::OFS_COND_ALM, 32'h0);
    check(rdv, 32'h1000);
    tripDiv <= 4'h3;
    cyc(6);
    check(shutdownCmd, 1'b1);
    check(loadOpen, 4'hf);
    cyc(DLY);
    resetAuto <= 1'b1;
    cyc(6);
    check(shutdownCmd, 1'b1);
    resetAuto <= 1'b0;
    tripDiv <= 4'h0;
    cyc(6);
    check(shutdownCmd, 1'b1);
    clear_all();
    tripDiv <= 4'h3;
    cyc(6);
    tripDiv <= 4'h0;
    resetAuto <= 1'b1;
    cyc(2);
    resetAuto <= 1'b0;
    cyc(6);
    check(shutdownCmd, 1'b1);
    clear_all();
    sensorBypassReq <= 4'h6;
    tripDiv <= 4'h6;
    cyc(6);
    check(shutdownCmd, 1'b0);
    bus(1'b0, prot_pkg::OFS_STATUS, 32'h0);
    check(rdv[15:12], 4'h2);
    check(divAlarm.sensorsBypassed, 4'h2);
    tripDiv <= 4'he;
    cyc(6);
    check(shutdownCmd, 1'b1);
    sensorBypassReq <= 4'h0;
    clear_all();
    for (int i = 0; i < 9; i++) begin
      modeSel <= cmode[i];
      capInsufficient <= {4{ccap[i]}};
      condBit <= cbit[i];
      tripDiv <= 4'h3;
      cyc(6);
      check(shutdownCmd, cexp[i]);
      clear_all();
    end
    modeSel <= prot_pkg::MODE_SHUTDOWN;
    cyc(6);
    check(shutdownCmd, 1'b1);
    bus(1'b0, prot_pkg::OFS_STATUS, 32'h0);
    check(rdv[prot_pkg::ST_MODE_SD], 1'b1);
    clear_all();
    manualA <= 1'b1;
    cyc(6);
    check(shutdownCmd, 1'b0);
    manualB <= 1'b1;
    cyc(6);
    check(shutdownCmd, 1'b1);
    check(divAlarm.autoTrip, 4'h0);
    manualA <= 1'b0;
    manualB <= 1'b0;
    cyc(DLY + 6);
    resetAuto <= 1'b1;
    cyc(6);
    resetAuto <= 1'b0;
    cyc(6);
    check(shutdownCmd, 1'b1);
    clear_all();
    divPowerGood <= 4'he;
    cyc(6);
    check(loadOpen, 4'h1);
    check(shutdownCmd, 1'b0);
    // an out-of-service division drops out of the output vote
    divPowerGood <= 4'hc;
    tluBypassReq <= 4'h5;
    cyc(6);
    check(shutdownCmd, 1'b0);
    check(loadOpen, 4'h3);
    check(divAlarm, 16'h1000);
    tluBypassReq <= 4'h0;
    cyc(8);
    check(shutdownCmd, 1'b1);
    clear_all();
    bus(1'b1, prot_pkg::OFS_CTRL, 32'h3);
    cyc(6);
    check(shutdownCmd, 1'b1);
    check(divAlarm.manualTrip, 4'h3);
    bus(1'b1, prot_pkg::OFS_CTRL, 32'h0);
    bus(1'b0, prot_pkg::OFS_CTRL, 32'h0);
    check(rdv, 32'h0);
    clear_all();
    // header low pressure trips until shutdown latches, then the bypass masks it
    headerBypassSw <= 1'b1;
    condBit <= 4'h3;
    tripDiv <= 4'h3;
    cyc(6);
    check(shutdownCmd, 1'b1);
    check(divAlarm.autoTrip, 4'h0);
    headerBypassSw <= 1'b0;
    condBit <= 4'hc;
    clear_all();
    fluxNonCoincident <= 1'b1;
    cyc(6);
    check(fluxModeAlarm, 1'b1);
    modeSel <= S;
    cyc(6);
    check(fluxModeAlarm, 1'b0);
    end_of_test();
  end
endmodule
